// ---- acr_ctrl.sv ----
// Second control register with result FIFO, data-available output and offset correction
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Soft reset bit restores both control registers
// - Soft reset clears FIFO pointers and offset
// - Five cycles after reset before first sample
// - Bit 1 reads back FIFO overflow flag
// - Reading the register clears overflow flag
// - Writing bit 1 empties FIFO, not stored
// - Bits 2-3 pick threshold; raise data-available
// - Bit 4: level or pulse, resets one
// - Bit 5: polarity, resets active high
// - Bit 6 set: write pin is direction
// - Bit 6 clear: separate read/write strobes
// - Bit 7: twos-complement or straight binary
// - Bit 8 write: zero-input conversion stores offset
// - Offset subtracted from every later result
// - Threshold count table by channel count
// - Level mode: drop on first read, recheck later
// - Pulse mode: short pulse, next after batch
module acr_ctrl #(
	parameter int DEPTH = acr_pkg::FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Host bus pins, active low strobes
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic reg_sel,
	input wire logic [acr_pkg::REG_W-1:0] data_in,
	output logic [acr_pkg::REG_W-1:0] data_out,
	// Converter side
	input wire logic sample_valid,
	input wire logic [acr_pkg::SAMPLE_W-1:0] sample_in,
	input wire logic [1:0] channel_count_m1,
	output logic zero_input,
	output logic conv_enable,
	// Event output and control register copies
	output logic data_available_out,
	output logic [acr_pkg::REG_W-1:0] ctrl_first,
	output logic [acr_pkg::REG_W-1:0] ctrl_second
);
	import acr_pkg::*;

	localparam int PW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) $error("acr_ctrl depth must be power of 2, >=16");
	end

	// ****************************************
	// Bus decode
	// ****************************************
	logic rd_act;
	logic wr_act;
	logic rd_q;
	logic wr_q;
	logic rd_fall;
	logic wr_rise;
	logic [REG_W-1:0] ctrl1;
	logic [REG_W-1:0] ctrl0;
	logic cal_done;

	// Combined direction pin when bit 6 set, else two strobes
	always_comb begin
		if (ctrl1[BIT_RW_COMBINED]) begin
			rd_act = !cs_n && wr_n;
			wr_act = !cs_n && !wr_n;
		end else begin
			rd_act = !cs_n && !rd_n && wr_n;
			wr_act = !cs_n && !wr_n && rd_n;
		end
	end

	// Edge detect of the internal strobes; inputs are already synchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else if (clk_en) begin
			rd_q <= rd_act;
			wr_q <= wr_act;
		end
	end
	assign rd_fall = rd_act && !rd_q;
	assign wr_rise = wr_act && !wr_q;

	wire wr1 = wr_rise && reg_sel;
	wire wr0 = wr_rise && !reg_sel;
	wire rd1 = rd_fall && reg_sel;
	wire rd0 = rd_fall && !reg_sel;
	wire soft_reset = wr1 && data_in[BIT_SOFT_RESET];
	wire fifo_clear = wr1 && data_in[BIT_OVERFLOW];

	// ****************************************
	// Control registers
	// ****************************************
	// Strobe bits are never stored; reads see bit 0 as zero and bit 1 as the overflow flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl1 <= CTRL1_RESET;
			ctrl0 <= '0;
		end else if (clk_en) begin
			if (soft_reset) begin
				ctrl1 <= CTRL1_RESET;
				ctrl0 <= '0;
			end else if (wr1) begin
				ctrl1 <= {1'b0, data_in[8:2], 2'b00};
			end else if (wr0) begin
				ctrl0 <= data_in;
			end
			if (ctrl1[BIT_OFFSET_CAL] && cal_done) ctrl1[BIT_OFFSET_CAL] <= 1'b0;
		end
	end

	// ****************************************
	// Start-up delay after any reset
	// ****************************************
	logic [2:0] start_cnt;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_cnt <= 3'(START_DELAY_CYC);
		end else if (clk_en) begin
			if (soft_reset) start_cnt <= 3'(START_DELAY_CYC);
			else if (start_cnt != 3'h0) start_cnt <= start_cnt - 3'h1;
		end
	end
	wire running = (start_cnt == 3'h0);

	// ****************************************
	// Offset calibration and coding
	// ****************************************
	logic [SAMPLE_W-1:0] offset;
	assign cal_done = running && sample_valid && ctrl1[BIT_OFFSET_CAL];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			offset <= '0;
		end else if (clk_en) begin
			if (soft_reset) offset <= '0;
			else if (cal_done) offset <= sample_in;
		end
	end

	// Result path: subtract offset, then recode; cal sample is not queued
	logic [SAMPLE_W-1:0] corrected;
	logic [SAMPLE_W-1:0] coded;
	assign corrected = sample_in - offset;
	assign coded = ctrl1[BIT_CODING] ? corrected : {~corrected[SAMPLE_W-1], corrected[SAMPLE_W-2:0]};

	acr_buf_if #(.W(SAMPLE_W)) b_in ();
	acr_buf_if #(.W(SAMPLE_W)) b_out ();
	assign b_in.data = coded;
	assign b_in.valid = running && sample_valid && !ctrl1[BIT_OFFSET_CAL];

	acr_skid #(.W(SAMPLE_W)) u_skid (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.flush(soft_reset || fifo_clear),
		.in_side(b_in),
		.out_side(b_out)
	);

	// ****************************************
	// Result FIFO
	// ****************************************
	logic [SAMPLE_W-1:0] fifo [DEPTH];
	logic [PW:0] wptr;
	logic [PW:0] rptr;
	logic [PW:0] fill;
	logic fifo_overflow_flag;
	assign fill = wptr - rptr;
	wire fifo_full = (fill == (PW+1)'(DEPTH));
	wire pop = rd0 && (fill != '0);
	assign b_out.ready = 1'b1;
	wire push = b_out.valid;

	// Pointers; a full FIFO with no pop in the same cycle drops the word and records an overflow
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr <= '0;
			rptr <= '0;
		end else if (clk_en) begin
			if (soft_reset || fifo_clear) begin
				wptr <= '0;
				rptr <= '0;
			end else begin
				if (push && (!fifo_full || pop)) wptr <= wptr + 1'b1;
				if (pop) rptr <= rptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && push && (!fifo_full || pop)) fifo[wptr[PW-1:0]] <= b_out.data;
	end

	// Overflow flag: a new overflow wins over the read that clears it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_overflow_flag <= 1'b0;
		end else if (clk_en) begin
			if (soft_reset) fifo_overflow_flag <= 1'b0;
			else if (push && fifo_full && !pop) fifo_overflow_flag <= 1'b1;
			else if (rd1) fifo_overflow_flag <= 1'b0;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= '0;
		end else if (clk_en) begin
			if (rd1) data_out <= {ctrl1[9:2], fifo_overflow_flag, 1'b0};
			else if (rd0) data_out <= fifo[rptr[PW-1:0]];
		end
	end

	// ****************************************
	// Data-available
	// ****************************************
	logic [4:0] thr;
	logic [4:0] reads_left;
	logic av_active;
	logic [3:0] pulse_cnt;
	assign thr = THR_TABLE[{channel_count_m1, ctrl1[BIT_THR_HI:BIT_THR_LO]}];
	wire trig = (thr != 5'h0) && ({1'b0, fill} >= 6'(thr));

	// Armed when reads_left is zero; after firing, wait for a batch of reads
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reads_left <= '0;
			av_active <= 1'b0;
			pulse_cnt <= '0;
		end else if (clk_en) begin
			if (soft_reset || fifo_clear) begin
				reads_left <= '0;
				av_active <= 1'b0;
				pulse_cnt <= '0;
			end else if (reads_left == 5'h0) begin
				if (trig) begin
					reads_left <= thr;
					av_active <= 1'b1;
					pulse_cnt <= 4'(PULSE_CYC);
				end
			end else begin
				if (pop) begin
					reads_left <= reads_left - 5'h1;
					if (!ctrl1[BIT_AV_TYPE]) av_active <= 1'b0;
				end
				if (ctrl1[BIT_AV_TYPE]) begin
					if (pulse_cnt > 4'h1) pulse_cnt <= pulse_cnt - 4'h1;
					else av_active <= 1'b0;
				end
			end
		end
	end

	// Output flops; polarity applied at the pin
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_available_out <= 1'b0;
			zero_input <= 1'b0;
			conv_enable <= 1'b0;
			ctrl_first <= '0;
			ctrl_second <= CTRL1_RESET;
		end else if (clk_en) begin
			data_available_out <= ctrl1[BIT_AV_POL] ? av_active : !av_active;
			zero_input <= ctrl1[BIT_OFFSET_CAL];
			conv_enable <= running;
			ctrl_first <= ctrl0;
			ctrl_second <= ctrl1;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_softrst;
		@(posedge clk) disable iff (!reset_n) clk_en && soft_reset |=> ctrl1 == CTRL1_RESET && wptr == '0;
	endproperty
	a_softrst: assert property (p_softrst) else $error("soft reset did not restore state");
	property p_offclr;
		@(posedge clk) disable iff (!reset_n) clk_en && soft_reset |=> offset == '0;
	endproperty
	a_offclr: assert property (p_offclr) else $error("offset not cleared");
	property p_start;
		@(posedge clk) disable iff (!reset_n) clk_en && soft_reset |=> !b_in.valid [*5];
	endproperty
	a_start: assert property (p_start) else $error("sample queued too early");
	property p_ovclr;
		@(posedge clk) disable iff (!reset_n) clk_en && rd1 && !(push && fifo_full) |=> !fifo_overflow_flag;
	endproperty
	a_ovclr: assert property (p_ovclr) else $error("overflow not cleared by read");
	property p_fclr;
		@(posedge clk) disable iff (!reset_n) clk_en && fifo_clear |=> fill == '0 && !ctrl1[BIT_OVERFLOW];
	endproperty
	a_fclr: assert property (p_fclr) else $error("fifo clear failed");
	property p_strobes;
		@(posedge clk) disable iff (!reset_n) ctrl1[BIT_SOFT_RESET] == 1'b0 && ctrl1[BIT_RESERVED] == 1'b0;
	endproperty
	a_strobes: assert property (p_strobes) else $error("strobe bit held");
	property p_level;
		@(posedge clk) disable iff (!reset_n) clk_en && !ctrl1[BIT_AV_TYPE] && pop && reads_left != 0 |=> !av_active;
	endproperty
	a_level: assert property (p_level) else $error("level not dropped on read");
	property p_pulse;
		@(posedge clk) disable iff (!reset_n) ctrl1[BIT_AV_TYPE] && $rose(av_active) && clk_en |=> ##[0:2] !av_active;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too long");
endmodule : acr_ctrl
`default_nettype wire

// ---- acr_pkg.sv ----
// Package of constants for the second converter control register block
package acr_pkg;
	// ****************************************
	// Register layout
	// ****************************************
	localparam int REG_W = 10;
	localparam int BIT_SOFT_RESET = 0;
	localparam int BIT_OVERFLOW = 1;
	localparam int BIT_THR_LO = 2;
	localparam int BIT_THR_HI = 3;
	localparam int BIT_AV_TYPE = 4;
	localparam int BIT_AV_POL = 5;
	localparam int BIT_RW_COMBINED = 6;
	localparam int BIT_CODING = 7;
	localparam int BIT_OFFSET_CAL = 8;
	localparam int BIT_RESERVED = 9;
	localparam logic [9:0] CTRL1_RESET = 10'h030;
	// ****************************************
	// Data path and timing
	// ****************************************
	localparam int SAMPLE_W = 10;
	localparam int FIFO_DEPTH = 16;
	localparam int START_DELAY_CYC = 5;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PULSE_TIME_PS = 4000;
	localparam int PULSE_CYC = (PULSE_TIME_PS / 2 / CLK_PERIOD_PS) < 1 ? 1 :
		(PULSE_TIME_PS / 2 / CLK_PERIOD_PS);
	// Threshold counts, index {channels-1, code}; zero marks reserved
	localparam logic [4:0] THR_TABLE [16] = '{
		5'h01, 5'h04, 5'h08, 5'h0e,
		5'h02, 5'h04, 5'h08, 5'h0c,
		5'h03, 5'h06, 5'h09, 5'h0c,
		5'h04, 5'h08, 5'h0c, 5'h00};
endpackage : acr_pkg

// ---- acr_buf_if.sv ----
// Interface carrying samples between the converter side and the result buffer
`timescale 1ns/1ps
`default_nettype none
interface acr_buf_if #(parameter int W = 10);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface : acr_buf_if
`default_nettype wire

// ---- acr_skid.sv ----
// Two-entry buffer between sample producer and result FIFO
`timescale 1ns/1ps
`default_nettype none
module acr_skid #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic flush,
	// Stream sides
	acr_buf_if.dst in_side,
	acr_buf_if.src out_side
);
	logic [W-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;

	initial begin
		if (W < 1) $error("acr_skid width must be positive");
	end

	assign in_side.ready = (count != 2'h2);
	assign out_side.valid = (count != 2'h0);
	assign out_side.data = mem[rd_ptr];

	// Pointer and count update; a stall downstream simply lets it fill
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr <= 1'b0;
				rd_ptr <= 1'b0;
				count <= 2'h0;
			end else begin
				if (in_side.valid && in_side.ready) wr_ptr <= ~wr_ptr;
				if (out_side.valid && out_side.ready) rd_ptr <= ~rd_ptr;
				count <= count + 2'((in_side.valid && in_side.ready) ? 1 : 0)
					- 2'((out_side.valid && out_side.ready) ? 1 : 0);
			end
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (clk_en && in_side.valid && in_side.ready) begin
			mem[wr_ptr] <= in_side.data;
		end
	end
endmodule : acr_skid
`default_nettype wire

// ---- acr_host.sv ----
// Host bus model that issues register and FIFO accesses to the control block
`timescale 1ns/1ps
`default_nettype none
module acr_host (
	// Clock and strobe mode
	input wire logic clk,
	input wire logic combined,
	// Bus pins towards the device
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic reg_sel,
	output logic [9:0] data_in,
	output logic rd_done
);
	// ****************************************
	// Bus cycles
	// ****************************************
	// Idle bus: deselected, strobes high
	initial begin
		{cs_n, rd_n, wr_n, reg_sel, rd_done} = 5'h1c;
		data_in = 10'h155;
	end
	// Strobe held over two edges so both the taken edge and the answer edge see it
	task automatic access(input logic is_rd, input logic sel, input logic [9:0] val);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		reg_sel = sel;
		data_in = is_rd ? ~data_in : val;
		rd_n = combined | ~is_rd;
		wr_n = is_rd;
		repeat (2) @(posedge clk);
		#1;
		{cs_n, rd_n, wr_n} = 3'h7;
		data_in = ~data_in; // Released bus must not look like held data
		rd_done = is_rd;
		@(posedge clk);
		#1;
		rd_done = 1'b0;
	endtask : access
endmodule : acr_host
`default_nettype wire

// ---- acr_ctrl_tb.sv ----
// Self-checking testbench for the second converter control register block
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_tb import acr_pkg::*; ;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk, reset_n, clk_en, cs_n, rd_n, wr_n, reg_sel, sample_valid, zero_input;
	logic conv_enable, data_available_out, rd_done, combined;
	logic [9:0] data_in, data_out, sample_in, ctrl_first, ctrl_second;
	logic [1:0] channel_count_m1;
	logic [9:0] exp_q [$];
	logic [9:0] s [4];
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	integer seed = 32'hf492;
	acr_ctrl i_acr_ctrl (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .reg_sel(reg_sel), .data_in(data_in), .data_out(data_out),
		.sample_valid(sample_valid), .sample_in(sample_in),
		.channel_count_m1(channel_count_m1), .zero_input(zero_input),
		.conv_enable(conv_enable), .data_available_out(data_available_out),
		.ctrl_first(ctrl_first), .ctrl_second(ctrl_second));
	acr_host i_acr_host (.clk(clk), .combined(combined), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .reg_sel(reg_sel), .data_in(data_in), .rd_done(rd_done));
	// ****************************************
	// Helpers
	// ****************************************
	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic complete_run();
		if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] e);
		n_compared++;
		if (seen !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, e, seen);
		end
	endtask : chk
	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			complete_run();
		end
	end
	// Read answers are compared against the oldest note
	always @(posedge clk) begin
		if (rd_done === 1'b1) chk("data_out", data_out, exp_q.pop_front());
	end
	task automatic rd(input logic sel, input logic [9:0] e);
		exp_q.push_back(e);
		i_acr_host.access(1'b1, sel, 10'h000);
	endtask : rd
	task automatic wr(input logic sel, input logic [9:0] v);
		i_acr_host.access(1'b0, sel, v);
	endtask : wr
	// One-cycle sample strobe, gap after it so the buffer never has to stall
	task automatic push(input logic [9:0] v);
		@(posedge clk);
		#1;
		sample_valid = 1'b1;
		sample_in = v;
		@(posedge clk);
		#1;
		sample_valid = 1'b0;
		sample_in = ~v;
	endtask : push
	task automatic wait_da(input logic lvl);
		for (int i = 0; i < 20 && data_available_out !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
		chk("data_available_out", 10'(data_available_out), 10'(lvl));
	endtask : wait_da
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		int n;
		{reset_n, clk_en, sample_valid, combined} = 4'h4;
		sample_in = 10'h000;
		channel_count_m1 = 2'h0;
		repeat (20) @(posedge clk);
		#1;
		reset_n = 1'b1;
		chk("ctrl_second", ctrl_second, CTRL1_RESET);
		rd(1'b1, 10'h030);
		wr(1'b1, 10'h0bc);
		chk("ctrl_second", ctrl_second, 10'h0bc);
		// Level, active high, binary, four samples to trigger
		wr(1'b1, 10'h0a4);
		for (int i = 0; i < 4; i++) s[i] = 10'($random(seed));
		for (int i = 0; i < 3; i++) push(s[i]);
		repeat (8) @(posedge clk);
		chk("data_available_out", 10'(data_available_out), 10'h000);
		push(s[3]);
		wait_da(1'b1);
		rd(1'b0, s[0]);
		chk("data_available_out", 10'(data_available_out), 10'h000);
		for (int i = 1; i < 4; i++) rd(1'b0, s[i]);
		// Overflow flag, cleared by reading, then FIFO clear
		for (int i = 0; i < 20; i++) push(10'($random(seed)));
		rd(1'b1, 10'h0a6);
		rd(1'b1, 10'h0a4);
		wr(1'b1, 10'h0a6);
		repeat (4) @(posedge clk);
		chk("data_available_out", 10'(data_available_out), 10'h000);
		rd(1'b1, 10'h0a4);
		// Offset calibration then twos-complement results
		wr(1'b1, 10'h124);
		repeat (2) @(posedge clk);
		chk("zero_input", 10'(zero_input), 10'h001);
		push(10'h003);
		repeat (4) @(posedge clk);
		chk("ctrl_second", ctrl_second, 10'h024);
		chk("zero_input", 10'(zero_input), 10'h000);
		for (int i = 0; i < 4; i++) s[i] = {1'b1, 9'($random(seed))};
		for (int i = 0; i < 4; i++) push(s[i]);
		wait_da(1'b1);
		for (int i = 0; i < 4; i++) rd(1'b0, (s[i] - 10'h003) ^ 10'h200);
		// Lowest threshold for every channel count
		wr(1'b1, 10'h0a0);
		for (int c = 0; c < 4; c++) begin
			channel_count_m1 = 2'(c);
			for (int i = 0; i < c; i++) push(10'($random(seed)));
			repeat (8) @(posedge clk);
			chk("data_available_out", 10'(data_available_out), 10'h000);
			push(10'h2aa);
			wait_da(1'b1);
			wr(1'b1, 10'h0a2);
		end
		// Soft reset restores both registers, offset and start-up delay
		wr(1'b0, 10'h155);
		chk("ctrl_first", ctrl_first, 10'h155);
		wr(1'b1, 10'h001);
		chk("ctrl_first", ctrl_first, 10'h000);
		chk("ctrl_second", ctrl_second, CTRL1_RESET);
		chk("conv_enable", 10'(conv_enable), 10'h000);
		for (n = 0; n < 20 && conv_enable !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("conv_enable", 10'(conv_enable), 10'h001);
		chk("start_delay", 10'(n), 10'(START_DELAY_CYC - 1));
		channel_count_m1 = 2'h0;
		s[0] = 10'($random(seed));
		push(s[0]);
		n = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			n += int'(data_available_out === 1'b1);
		end
		chk("pulse_width", 10'(n), 10'(PULSE_CYC));
		rd(1'b0, s[0] ^ 10'h200);
		// Combined direction input, then active low idle level
		wr(1'b1, 10'h070);
		combined = 1'b1;
		rd(1'b1, 10'h070);
		wr(1'b1, 10'h000);
		combined = 1'b0;
		chk("ctrl_second", ctrl_second, 10'h000);
		chk("data_available_out", 10'(data_available_out), 10'h001);
		rd(1'b1, 10'h000);
		// Clock enable low: a write must leave the register untouched
		clk_en = 1'b0;
		wr(1'b1, 10'h0a0);
		clk_en = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("ctrl_second", ctrl_second, 10'h000);
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule : acr_ctrl_tb
`default_nettype wire
